// File: common/pio_regs.vh
`ifndef PIO_REGS_VH
`define PIO_REGS_VH

// Register indices on the port bus (address width 3).
`define PIO_ADDR_W          3
`define PIO_P0_DATA         3'h0
`define PIO_P0_DIR          3'h1
`define PIO_P1_DATA         3'h2
`define PIO_P1_DIR          3'h3
`define PIO_P2_DATA         3'h4
`define PIO_STBY_CTRL       3'h5

// Field positions.
`define PIO_STOP_FLOAT_BIT  0
`define PIO_P1_CNT_CLK_BIT  3
`define PIO_P1_IRQ_LO_BIT   4
`define PIO_P1_IRQ_HI_BIT   6

// Reset values.
`define PIO_DIR_RST         8'h00
`define PIO_LATCH_RST       8'h00
`define PIO_P2_LATCH_RST    6'h3f
`define PIO_STBY_RST        8'h00

`endif

// File: rtl/pio_ports.v
`timescale 1ns/1ns
`include "pio_regs.vh"

// One bidirectional port: latch, direction, pin drive and pin sampling.
module pio_bidir #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             nrst,
  // Register writes
  input  wire             wr_data,
  input  wire             wr_dir,
  input  wire [WIDTH-1:0] wdata,
  // Peripheral override
  input  wire [WIDTH-1:0] periph_oe,
  input  wire [WIDTH-1:0] periph_out,
  input  wire             float_all,
  // Pins
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out,
  output reg  [WIDTH-1:0] pin_oe,
  // State seen by software and peripherals
  output reg  [WIDTH-1:0] latch,
  output reg  [WIDTH-1:0] dir,
  output reg  [WIDTH-1:0] pin_level
);

  reg  [WIDTH-1:0] pin_meta;
  reg  [WIDTH-1:0] next_pin_out;
  reg  [WIDTH-1:0] next_pin_oe;
  reg  [WIDTH-1:0] next_latch;
  reg  [WIDTH-1:0] next_dir;

  // Latch takes every write regardless of direction.
  always @*
  begin
    next_latch = latch;
    if (wr_data)
      next_latch = wdata;
  end

  always @*
  begin
    next_dir = dir;
    if (wr_dir)
      next_dir = wdata;
  end

  // A peripheral output wins over the direction bit; stop float wins over all.
  always @*
  begin
    next_pin_oe  = (next_dir | periph_oe) & {WIDTH{~float_all}};
    next_pin_out = (periph_oe & periph_out) | (~periph_oe & next_latch);
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      latch     <= {WIDTH{1'b0}};
      dir       <= {WIDTH{1'b0}};
      pin_oe    <= {WIDTH{1'b0}};
      pin_out   <= {WIDTH{1'b0}};
      pin_meta  <= {WIDTH{1'b0}};
      pin_level <= {WIDTH{1'b0}};
    end
    else
    begin
      latch     <= next_latch;
      dir       <= next_dir;
      pin_oe    <= next_pin_oe;
      pin_out   <= next_pin_out;
      pin_meta  <= pin_in;
      pin_level <= pin_meta;
    end
  end

endmodule

`timescale 1ns/1ns

module pio_ports (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   nrst,
  // Register port
  input  wire [`PIO_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr,
  input  wire                   rd,
  input  wire                   rd_rmw,
  output reg  [7:0]             rdata,
  // Power state
  input  wire                   stop_mode,
  // Port 0 pins
  input  wire [7:0]             p0_in,
  output wire [7:0]             p0_out,
  output wire [7:0]             p0_oe,
  // Port 1 pins
  input  wire [7:0]             p1_in,
  output wire [7:0]             p1_out,
  output wire [7:0]             p1_oe,
  // Port 2 open-drain pins
  output wire [5:0]             p2_out,
  output wire [5:0]             p2_oe,
  // Port 1 peripheral outputs (timer output, remote carrier and others)
  input  wire [7:0]             p1_periph_oe,
  input  wire [7:0]             p1_periph_out,
  // Peripheral inputs
  output wire [7:0]             edge_irq_group2_input,
  output wire [2:0]             edge_irq_group1_input,
  output wire                   counter_clock_input,
  output wire [7:0]             p1_pin_level
);

  wire [7:0] p0_latch;
  wire [7:0] p0_dir;
  wire [7:0] p0_level;
  wire [7:0] p1_latch;
  wire [7:0] p1_dir;
  wire [5:0] pin_value_latch;
  reg  [7:0] stby_ctrl;
  reg  [7:0] next_rdata;
  reg        float_now;
  wire       stop_pin_float;
  wire       float_all;
  wire       wr_p0_data;
  wire       wr_p0_dir;
  wire       wr_p1_data;
  wire       wr_p1_dir;
  wire       wr_p2_data;

  assign stop_pin_float = stby_ctrl[`PIO_STOP_FLOAT_BIT];
  assign float_all      = stop_mode & stop_pin_float;

  assign wr_p0_data = wr && (addr == `PIO_P0_DATA);
  assign wr_p0_dir  = wr && (addr == `PIO_P0_DIR);
  assign wr_p1_data = wr && (addr == `PIO_P1_DATA);
  assign wr_p1_dir  = wr && (addr == `PIO_P1_DIR);
  assign wr_p2_data = wr && (addr == `PIO_P2_DATA);

  // Port 0 has no peripheral outputs, only interrupt inputs.
  pio_bidir #(
    .WIDTH      (8)
  ) u_port0 (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .wr_data    (wr_p0_data),
    .wr_dir     (wr_p0_dir),
    .wdata      (wdata),
    .periph_oe  (8'h00),
    .periph_out (8'h00),
    .float_all  (float_all),
    .pin_in     (p0_in),
    .pin_out    (p0_out),
    .pin_oe     (p0_oe),
    .latch      (p0_latch),
    .dir        (p0_dir),
    .pin_level  (p0_level)
  );

  pio_bidir #(
    .WIDTH      (8)
  ) u_port1 (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .wr_data    (wr_p1_data),
    .wr_dir     (wr_p1_dir),
    .wdata      (wdata),
    .periph_oe  (p1_periph_oe),
    .periph_out (p1_periph_out),
    .float_all  (float_all),
    .pin_in     (p1_in),
    .pin_out    (p1_out),
    .pin_oe     (p1_oe),
    .latch      (p1_latch),
    .dir        (p1_dir),
    .pin_level  (p1_pin_level)
  );

  // Synchronised pin levels feed peripherals whatever the direction.
  assign edge_irq_group2_input = p0_level;
  assign edge_irq_group1_input = p1_pin_level[`PIO_P1_IRQ_HI_BIT:`PIO_P1_IRQ_LO_BIT];
  assign counter_clock_input   = p1_pin_level[`PIO_P1_CNT_CLK_BIT];

  // Port 2 is output only; it has no pin sampling at all.
  pio_drain #(
    .WIDTH     (6),
    .LATCH_RST (`PIO_P2_LATCH_RST)
  ) u_port2 (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .wr_data   (wr_p2_data),
    .wdata     (wdata[5:0]),
    .float_all (float_now),
    .pin_out   (p2_out),
    .pin_oe    (p2_oe),
    .latch     (pin_value_latch)
  );

  // Read mux; port 0 and 1 data reads return pins unless read-modify-write; port 2 data reads always return its latch.
  always @*
  begin
    next_rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        `PIO_P0_DATA:   next_rdata = rd_rmw ? p0_latch : p0_level;
        `PIO_P0_DIR:    next_rdata = p0_dir;
        `PIO_P1_DATA:   next_rdata = rd_rmw ? p1_latch : p1_pin_level;
        `PIO_P1_DIR:    next_rdata = p1_dir;
        `PIO_P2_DATA:   next_rdata = {2'b00, pin_value_latch};
        `PIO_STBY_CTRL: next_rdata = stby_ctrl;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  always @*
  begin
    float_now = float_all;
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stby_ctrl       <= `PIO_STBY_RST;
      rdata           <= 8'h00;
    end
    else
    begin
      if (wr && (addr == `PIO_STBY_CTRL))
        stby_ctrl     <= {7'h00, wdata[`PIO_STOP_FLOAT_BIT]};
      rdata           <= next_rdata;
    end
  end

endmodule

// One open-drain output port: latch, pull-down enable and release in stop.
module pio_drain #(
  parameter             WIDTH     = 6,
  parameter [WIDTH-1:0] LATCH_RST = {WIDTH{1'b1}}
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             nrst,
  // Register writes
  input  wire             wr_data,
  input  wire [WIDTH-1:0] wdata,
  // Stop float
  input  wire             float_all,
  // Pins
  output reg  [WIDTH-1:0] pin_out,
  output reg  [WIDTH-1:0] pin_oe,
  // State seen by software
  output reg  [WIDTH-1:0] latch
);

  reg  [WIDTH-1:0] next_latch;
  reg  [WIDTH-1:0] next_pin_oe;

  // The latch takes every write, and the pins follow the latch.
  always @*
  begin
    next_latch = latch;
    if (wr_data)
      next_latch = wdata;
  end

  // A 0 pulls the pin low; a 1, or a float in stop, releases it.
  always @*
  begin
    next_pin_oe = ~next_latch & {WIDTH{~float_all}};
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      latch   <= LATCH_RST;
      pin_out <= {WIDTH{1'b0}};
      pin_oe  <= {WIDTH{1'b0}};
    end
    else
    begin
      latch   <= next_latch;
      pin_out <= {WIDTH{1'b0}};
      pin_oe  <= next_pin_oe;
    end
  end

endmodule

// File: testbench/pio_ports_monitor.sv
`timescale 1ns/1ns
module pio_ports_monitor (
  // Clock, reset and bus
  input wire       core_clk, nrst, wr, rd, stop_mode, counter_clock_input,
  input wire [2:0] addr, edge_irq_group1_input,
  input wire [7:0] wdata, rdata,
  // Bidirectional pins and peripherals
  input wire [7:0] p0_in, p0_oe, p1_oe, p1_out, p1_periph_oe, p1_periph_out, edge_irq_group2_input, p1_pin_level,
  // Open-drain pins
  input wire [5:0] p2_out, p2_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_unmapped_zero: assert property (rd && addr[2:1] == 2'b11 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_float: assert property ($rose(nrst) |-> (p0_oe | p1_oe | {2'h0, p2_oe}) == 8'h00)
    else $error("pin driven after reset");
  a_drain_low: assert property (p2_out == 6'h00)
    else $error("open-drain drives high");
  a_periph_force: assert property (!stop_mode |=> (p1_oe & $past(p1_periph_oe)) == $past(p1_periph_oe))
    else $error("peripheral enable ignored");
  a_periph_value: assert property (!stop_mode |=> ((p1_out ^ $past(p1_periph_out)) & $past(p1_periph_oe)) == 8'h00)
    else $error("peripheral value lost");
  a_irq_sync: assert property ($past(nrst, 2) |-> edge_irq_group2_input == $past(p0_in, 2))
    else $error("pin level not fed to interrupt");
  a_p1_funcs: assert property (counter_clock_input == p1_pin_level[3] && edge_irq_group1_input == p1_pin_level[6:4])
    else $error("port1 functions misrouted");
  a_stop_float: assert property (wr && addr == 3'h5 && wdata[0] && stop_mode ##1 stop_mode |=> (p0_oe | p1_oe) == 8'h00
    && p2_oe == 6'h00)
    else $error("pins driven in stop");
endmodule

// File: testbench/pio_pins.sv
`timescale 1ns/1ns
module pio_pins (
  // Pad drive and external levels
  input  wire [7:0] p0_out, p0_oe, p1_out, p1_oe, ext0, ext1,
  input  wire [5:0] p2_oe,
  // Resolved pad levels
  output wire [7:0] p0_in, p1_in,
  output wire [5:0] p2_pin
);
  assign p0_in = (p0_out & p0_oe) | (ext0 & ~p0_oe);
  assign p1_in = (p1_out & p1_oe) | (ext1 & ~p1_oe);
  // Released open-drain pads rest high on an external pull-up.
  assign p2_pin = ~p2_oe;
endmodule

// File: testbench/pio_ports_tb.sv
`timescale 1ns/1ns
module pio_ports_tb;
  logic       core_clk = 0, nrst = 0, wr = 0, rd = 0, rmw = 0, stop = 0, rd_d = 0;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0, e0 = 0, e1 = 0, pe = 0, po = 0, r;
  wire  [7:0] rdata, p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
  wire  [5:0] p2_out, p2_oe, p2_pin;
  wire        cnt;
  logic [7:0] q[$];
  int         n_mismatch = 0, n_checks = 0, seed = 41;
  always #50 core_clk = ~core_clk;
  pio_ports i_dut (.core_clk, .nrst, .addr, .wdata, .wr, .rd, .rd_rmw(rmw), .rdata, .stop_mode(stop), .p0_in,
    .p0_out, .p0_oe, .p1_in, .p1_out, .p1_oe, .p2_out, .p2_oe, .p1_periph_oe(pe), .p1_periph_out(po),
    .edge_irq_group2_input(), .edge_irq_group1_input(), .counter_clock_input(cnt), .p1_pin_level());
  pio_pins i_pins (.p0_out, .p0_oe, .p1_out, .p1_oe, .ext0(e0), .ext1(e1), .p2_oe, .p0_in, .p1_in, .p2_pin);
  task chk(input logic [7:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One bus cycle; for a read, d is the expected data.
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic m);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    rmw <= m;
    if (!w)
      q.push_back(d);
    @(posedge core_clk);
    wr <= 0;
    rd <= 0;
  endtask
  task idle;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    if (rd_d)
      chk(rdata, q.pop_front());
    rd_d <= rd;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    idle;
    chk(p0_oe | p1_oe | {2'h0, p2_oe}, 8'h00);
    acc(0, 3'h4, 8'h3f, 0);
    r = 8'($random(seed));
    e0 <= ~r;
    acc(1, 3'h0, r, 0);
    idle;
    acc(0, 3'h0, ~r, 0);
    acc(0, 3'h0, r, 1);
    acc(1, 3'h1, 8'h0f, 0);
    idle;
    chk(p0_oe, 8'h0f);
    chk(p0_out & 8'h0f, r & 8'h0f);
    acc(0, 3'h0, r ^ 8'hf0, 0);
    e1 <= 8'($random(seed));
    @(posedge core_clk);
    pe <= 8'h90;
    po <= 8'h80;
    idle;
    chk(p1_oe, 8'h90);
    chk({7'h0, cnt}, {7'h0, e1[3]});
    acc(0, 3'h2, e1 & 8'h6f | 8'h80, 0);
    acc(1, 3'h4, 8'h3c, 0);
    idle;
    chk({2'h0, p2_oe}, 8'h03);
    acc(0, 3'h4, 8'h3c, 1);
    stop <= 1;
    acc(1, 3'h5, 8'h01, 0);
    idle;
    chk(p0_oe | p1_oe | {2'h0, p2_oe}, 8'h00);
    acc(0, 3'h5, 8'h01, 0);
    stop <= 0;
    idle;
    chk(p0_oe, 8'h0f);
    acc(1, 3'h7, 8'hff, 0);
    acc(0, 3'h7, 8'h00, 0);
    idle;
    test_done;
  end
endmodule
bind pio_ports pio_ports_monitor i_mon (.core_clk, .nrst, .wr, .rd, .stop_mode, .counter_clock_input, .addr,
  .edge_irq_group1_input, .wdata, .rdata, .p0_in, .p0_oe, .p1_oe, .p1_out, .p1_periph_oe, .p1_periph_out,
  .edge_irq_group2_input, .p1_pin_level, .p2_out, .p2_oe);
